// ===== core/psbp_port.sv
/*
 Processor side of the multiplexed 64-bit system address/data bus.
 Assumes the agent keeps its own pin rules, and that pins are synchronous
 to clk_sys. Core requests enter through a 32-word FIFO.
*/
`timescale 1ns/1ns
// Summary of operation
// - The port drives release_n low as it hands the bus to the agent.
// - The port marks each word it drives with outbound_valid_n low.
// - Address and data share one 64-bit lane, told apart by the command.
// - An 8-bit check lane carries byte parity in data cycles.
// - Commands and identifiers travel on a 9-bit lane beside the bus.
// - The command parity pin is ignored as input and driven as zero.
// - Outputs follow clk_sys; pipeline ratio is fixed at boot.
// - A mode bit picks integer or half ratios, a 3-bit field the ratio.
// - A null request from the agent returns mastership to the port.
module psbp_port (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic bootHalfMode,
    input wire logic [2:0] bootRatioSel,
    output logic [4:0] pipeRatioHalves,
    input wire logic [psbp_pkg::DATA_W-1:0] coreAddrData,
    input wire logic [psbp_pkg::CMD_W-1:0] coreCmd,
    input wire logic coreValid,
    output logic coreReady,
    output logic [6:0] intReg,
    input wire logic agent_request_n,
    output logic release_n,
    input wire logic read_accept_n,
    input wire logic write_accept_n,
    input wire logic inbound_valid_n,
    output logic outbound_valid_n,
    input wire logic [psbp_pkg::DATA_W-1:0] shared_addr_data_bus_in,
    output logic [psbp_pkg::DATA_W-1:0] shared_addr_data_bus_out,
    output logic shared_addr_data_bus_oe,
    input wire logic [psbp_pkg::CHECK_W-1:0] shared_bus_check_bits_in,
    output logic [psbp_pkg::CHECK_W-1:0] shared_bus_check_bits_out,
    output logic shared_bus_check_bits_oe,
    input wire logic [psbp_pkg::CMD_W-1:0] command_identifier_lane_in,
    output logic [psbp_pkg::CMD_W-1:0] command_identifier_lane_out,
    output logic command_identifier_lane_oe,
    input wire logic command_lane_parity_in,
    output logic command_lane_parity_out,
    output logic command_lane_parity_oe
);
    import psbp_pkg::*;

    psbp_state_t state_r;
    psbp_word_t qWord;
    logic qValid;
    logic qReady;
    logic isRead;
    logic isWrite;
    logic canIssue;
    logic extWrPend_r;
    logic inValid;
    logic [DATA_W-1:0] busOut_r;
    logic [CMD_W-1:0] cmdOut_r;
    logic [CHECK_W-1:0] chkOut_r;
    logic outbound_valid_n_r;
    logic master;

    psbp_fifo #(
        .WIDTH(DATA_W + CMD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inData({coreAddrData, coreCmd}),
        .inValid(coreValid),
        .inReady(coreReady),
        .outData(qWord),
        .outValid(qValid),
        .outReady(qReady)
    );

    // Ratio taken once at boot; the multiplier itself is analog
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pipeRatioHalves <= ratioHalves(bootHalfMode, bootRatioSel);
        end
    end

    assign inValid = !inbound_valid_n;
    assign master = (state_r == PSBP_MASTER);
    assign isRead = !qWord.cmd[CMD_DATA_BIT] && (qWord.cmd == CMD_READ);
    assign isWrite = !isRead;
    // Writes gate only their address cycle; data cycles follow freely
    assign canIssue = isRead ? !read_accept_n
        : (qWord.cmd[CMD_DATA_BIT] || !write_accept_n);
    // Queue drains before release, so a request never stalls a full queue
    assign qReady = master && canIssue;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= PSBP_MASTER;
        end else begin
            unique case (state_r)
                PSBP_MASTER: begin
                    if (!agent_request_n && !qValid) begin
                        state_r <= PSBP_RELEASE;
                    end
                end
                PSBP_RELEASE: state_r <= PSBP_SLAVE;
                PSBP_SLAVE: begin
                    if (inValid && command_identifier_lane_in == CMD_NULL) begin
                        state_r <= PSBP_MASTER;
                    end
                end
                default: state_r <= PSBP_MASTER;
            endcase
        end
    end

    assign release_n = (state_r != PSBP_RELEASE);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            busOut_r <= '0;
            cmdOut_r <= '0;
            chkOut_r <= '0;
            outbound_valid_n_r <= 1'b0;
        end else begin
            outbound_valid_n_r <= qValid && qReady;
            if (qValid && qReady) begin
                busOut_r <= qWord.addrData;
                cmdOut_r <= qWord.cmd;
                chkOut_r <= qWord.cmd[CMD_DATA_BIT]
                    ? byteParity(qWord.addrData) : '0;
            end
        end
    end

    // Interrupt register written by the agent while it owns the bus
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            extWrPend_r <= 1'b0;
            intReg <= INTREG_RST;
        end else if (state_r == PSBP_SLAVE && inValid) begin
            if (command_identifier_lane_in == CMD_EXTWR) begin
                extWrPend_r <= 1'b1;
            end else if (extWrPend_r
                && command_identifier_lane_in[CMD_DATA_BIT]) begin
                intReg <= shared_addr_data_bus_in[6:0];
                extWrPend_r <= 1'b0;
            end
        end
    end

    assign outbound_valid_n = !outbound_valid_n_r;
    assign shared_addr_data_bus_out = busOut_r;
    assign command_identifier_lane_out = cmdOut_r;
    assign shared_bus_check_bits_out = chkOut_r;
    assign shared_addr_data_bus_oe = master;
    assign shared_bus_check_bits_oe = master;
    assign command_identifier_lane_oe = master;
    assign command_lane_parity_out = 1'b0;
    assign command_lane_parity_oe = master;

    // Ownership and handover
    a_release_once: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !release_n |=> release_n && !shared_addr_data_bus_oe)
        else $error("release not followed by slave state");
    a_release_follows: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (master && !agent_request_n && !qValid) |=> !release_n)
        else $error("request with empty queue did not release");
    a_null_return: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (state_r == PSBP_SLAVE && inValid
        && command_identifier_lane_in == CMD_NULL)
        |=> shared_addr_data_bus_oe)
        else $error("null request did not return mastership");
    a_slave_tristate: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (state_r != PSBP_MASTER) |-> !shared_addr_data_bus_oe
        && !shared_bus_check_bits_oe && !command_identifier_lane_oe
        && outbound_valid_n)
        else $error("driving lanes while slave");

    // Flow control
    a_read_gate: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (qValid && qReady && isRead) |-> !read_accept_n)
        else $error("read issued without read_accept");
    a_write_gate: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (qValid && qReady && isWrite && !qWord.cmd[CMD_DATA_BIT])
        |-> !write_accept_n)
        else $error("write issued without write_accept");
    a_issue_valid: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (qValid && qReady) |=> !outbound_valid_n)
        else $error("issued word not marked valid");
    a_valid_out: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !outbound_valid_n |-> shared_addr_data_bus_oe
        && command_identifier_lane_oe)
        else $error("valid out while not driving");

    // Lane contents and boot ratio
    a_cmd_follows: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (qValid && qReady)
        |=> command_identifier_lane_out == $past(qWord.cmd))
        else $error("command lane does not carry issued command");
    a_check_lane: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (!outbound_valid_n && command_identifier_lane_out[CMD_DATA_BIT])
        |-> shared_bus_check_bits_out
        == byteParity(shared_addr_data_bus_out))
        else $error("check bits mismatch");
    a_check_addr: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        (!outbound_valid_n && !command_identifier_lane_out[CMD_DATA_BIT])
        |-> shared_bus_check_bits_out == '0)
        else $error("check bits not zero on address cycle");
    a_cmd_parity: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        command_lane_parity_out == 1'b0)
        else $error("command parity not zero");
    a_ratio_held: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        !sys_rst |=> $stable(pipeRatioHalves))
        else $error("clock ratio changed outside reset");
endmodule : psbp_port

// ===== core/psbp_pkg.sv
/*
 Package for the processor system bus port: lane widths, command codes,
 carrier structs, FIFO geometry and clock-ratio decode.
 Assumes a single 20 MHz system clock domain.
*/
package psbp_pkg;
    localparam int DATA_W = 64;
    localparam int CHECK_W = 8;
    localparam int CMD_W = 9;
    localparam int FIFO_DEPTH = 32;
    // Bit 8 of the command lane: 0 = address/command cycle, 1 = data cycle
    localparam int CMD_DATA_BIT = 8;
    localparam logic [8:0] CMD_READ = 9'h000;
    localparam logic [8:0] CMD_WRITE = 9'h080;
    localparam logic [8:0] CMD_NULL = 9'h180;
    localparam logic [8:0] CMD_WDATA = 9'h100;
    localparam logic [8:0] CMD_EXTWR = 9'h0C0;
    localparam logic [2:0] RATIO_RST = 3'h0;
    localparam logic MODE_RST = 1'b0;
    localparam logic [6:0] INTREG_RST = 7'h00;

    typedef struct packed {
        logic [DATA_W-1:0] addrData;
        logic [CMD_W-1:0] cmd;
    } psbp_word_t;

    typedef enum logic [1:0] {
        PSBP_MASTER = 2'b00,
        PSBP_RELEASE = 2'b01,
        PSBP_SLAVE = 2'b10
    } psbp_state_t;

    // Even parity per byte lane
    function automatic logic [CHECK_W-1:0] byteParity(
        input logic [DATA_W-1:0] d);
        logic [CHECK_W-1:0] p;
        p = '0;
        for (int i = 0; i < CHECK_W; i++) begin
            p[i] = ^d[i*8 +: 8];
        end
        return p;
    endfunction : byteParity

    // Pipeline multiplier in half steps (value = 2 x ratio)
    function automatic logic [4:0] ratioHalves(input logic halfMode,
        input logic [2:0] sel);
        logic [4:0] r;
        r = 5'(({2'b00, sel} + 5'h02) * 5'h02);
        if (halfMode) begin
            r = 5'(r / 5'h02);
        end
        return r;
    endfunction : ratioHalves
endpackage : psbp_pkg

// ===== core/psbp_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module psbp_fifo #(
    parameter int WIDTH = 73,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_r];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= AW'(wrPtr_r + 1'b1);
            end
            if (pop) begin
                rdPtr_r <= AW'(rdPtr_r + 1'b1);
            end
            count_r <= (AW+1)'(count_r + push - pop);
        end
    end
endmodule : psbp_fifo

// ===== testbench/psbp_agent.sv
/*
 Behavioural system agent facing the bus port.
 Assumes clk_sys and a bench that steers the stall inputs.
*/
`timescale 1ns/1ns
module psbp_agent
    import psbp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rdStall,
    input wire logic wrStall,
    input wire logic portOe,
    output logic agent_request_n,
    output logic read_accept_n,
    output logic write_accept_n,
    output logic inbound_valid_n,
    output psbp_pkg::psbp_word_t inWord
);
    assign read_accept_n = rdStall;
    assign write_accept_n = wrStall;
    initial begin
        agent_request_n = 1'b1;
        inbound_valid_n = 1'b1;
        inWord = '0;
    end
    // Idle lanes toggle so a stale word never looks valid
    always @(posedge clk_sys) begin
        if (inbound_valid_n) begin
            inWord <= ~inWord;
        end
    end
    task automatic send(input psbp_word_t w);
        inWord = w;
        inbound_valid_n = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : send
    task automatic takeBus(input logic [6:0] v);
        int n;
        agent_request_n = 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (portOe !== 1'b0 && n < 20);
        // The port only listens once it has left the release cycle
        @(posedge clk_sys);
        #1;
        send({64'h0, CMD_EXTWR});
        send({57'h0, v, CMD_WDATA});
        agent_request_n = 1'b1;
        send({64'h0, CMD_NULL});
        inbound_valid_n = 1'b1;
    endtask : takeBus
endmodule : psbp_agent

// ===== testbench/processor_system_bus_port_bench.sv
/*
 Self-checking bench for the system bus port.
 Assumes the agent model and a 50 ns clock.
*/
`timescale 1ns/1ns
module processor_system_bus_port_bench;
    import psbp_pkg::*;
    logic clk_sys, sys_rst, bootHalfMode, coreValid, coreReady;
    logic [2:0] bootRatioSel;
    logic [4:0] ratio;
    logic [6:0] intReg;
    logic [63:0] busOut;
    logic [7:0] chkOut;
    logic [8:0] cmdOut;
    logic busOe, parOut, release_n, outbound_valid_n, rdStall, wrStall;
    logic chkOe, cmdOe, parOe;
    logic reqN, rdN, wrN, inValidN;
    psbp_word_t coreIn, inWord, w;
    psbp_word_t exp[$];
    int mismatches = 0;
    int n_tests = 0;
    int relCnt = 0;
    psbp_port i_psbp_port (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bootHalfMode(bootHalfMode), .bootRatioSel(bootRatioSel),
        .pipeRatioHalves(ratio), .coreAddrData(coreIn.addrData),
        .coreCmd(coreIn.cmd), .coreValid(coreValid),
        .coreReady(coreReady), .intReg(intReg),
        .agent_request_n(reqN), .release_n(release_n),
        .read_accept_n(rdN), .write_accept_n(wrN),
        .inbound_valid_n(inValidN), .outbound_valid_n(outbound_valid_n),
        .shared_addr_data_bus_in(inWord.addrData),
        .shared_addr_data_bus_out(busOut),
        .shared_addr_data_bus_oe(busOe),
        .shared_bus_check_bits_in(8'h00),
        .shared_bus_check_bits_out(chkOut),
        .shared_bus_check_bits_oe(chkOe),
        .command_identifier_lane_in(inWord.cmd),
        .command_identifier_lane_out(cmdOut),
        .command_identifier_lane_oe(cmdOe),
        .command_lane_parity_in(1'b0),
        .command_lane_parity_out(parOut),
        .command_lane_parity_oe(parOe));
    psbp_agent i_psbp_agent (.clk_sys(clk_sys), .rdStall(rdStall),
        .wrStall(wrStall), .portOe(busOe), .agent_request_n(reqN),
        .read_accept_n(rdN), .write_accept_n(wrN),
        .inbound_valid_n(inValidN), .inWord(inWord));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] par(input logic [63:0] d);
        logic [7:0] p;
        for (int i = 0; i < 8; i++) begin
            p[i] = ^d[8*i +: 8];
        end
        return p;
    endfunction : par
    task automatic check(input string what, input logic [72:0] seen,
        input logic [72:0] want);
        n_tests++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    always @(posedge clk_sys) begin
        if (outbound_valid_n === 1'b0) begin
            w = exp.size() ? exp.pop_front() : 'x;
            check("word", {busOut, cmdOut}, w);
            check("chk", 73'(chkOut),
                73'(w.cmd[8] ? par(w.addrData) : 8'h00));
            check("cmdpar", 73'(parOut), 73'(0));
            check("oe", 73'({busOe, chkOe, cmdOe, parOe}), 73'(4'hF));
        end
        if (release_n === 1'b0) begin
            relCnt++;
            check("reloe", 73'({busOe, chkOe, cmdOe, parOe}), 73'(4'h0));
        end
    end
    task automatic doReset(input logic h, input logic [2:0] s,
        input logic [4:0] e);
        sys_rst = 1'b1;
        bootHalfMode = h;
        bootRatioSel = s;
        repeat (16) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        check("ratio", 73'(ratio), 73'(e));
    endtask : doReset
    // Leaves coreValid high so back-to-back pushes never glitch it
    task automatic push(input psbp_word_t x);
        logic ok;
        coreValid = 1'b1;
        coreIn = x;
        do begin
            ok = coreReady;
            @(posedge clk_sys);
            #1;
        end while (ok !== 1'b1);
        exp.push_back(x);
    endtask : push
    task automatic drain();
        int n = 0;
        coreValid = 1'b0;
        while (exp.size() != 0 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        #1 check("left", 73'(exp.size()), 73'(0));
    endtask : drain
    task automatic testFlow();
        push({64'h0000_1000_0000_0040, CMD_WRITE});
        push({64'h0123_4567_89AB_CDEF, CMD_WDATA});
        push({64'h0000_2000_0000_0080, CMD_READ});
        drain();
    endtask : testFlow
    task automatic testStall();
        {rdStall, wrStall} = 2'b11;
        push({64'h0000_0000_0000_0100, CMD_WRITE});
        push({64'h0000_0000_0000_0200, CMD_READ});
        coreValid = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 check("wrheld", 73'(exp.size()), 73'(2));
        wrStall = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 check("rdheld", 73'(exp.size()), 73'(1));
        rdStall = 1'b0;
        drain();
    endtask : testStall
    task automatic testFill();
        int n = 0;
        wrStall = 1'b1;
        coreValid = 1'b1;
        for (int i = 0; i < 40; i++) begin
            coreIn = {64'(i), CMD_WRITE};
            if (coreReady === 1'b1) begin
                n++;
                exp.push_back(coreIn);
            end
            @(posedge clk_sys);
            #1;
        end
        coreValid = 1'b0;
        check("filled", 73'(n), 73'(FIFO_DEPTH));
        wrStall = 1'b0;
        drain();
    endtask : testFill
    task automatic testHand();
        relCnt = 0;
        i_psbp_agent.takeBus(7'h55);
        @(posedge clk_sys);
        #1 check("intreg", 73'(intReg), 73'(7'h55));
        check("pulses", 73'(relCnt), 73'(1));
        check("back", 73'(busOe), 73'(1));
    endtask : testHand
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    initial begin
        #(50 * 20000);
        mismatches++;
        finish_test();
    end
    initial begin
        {coreValid, rdStall, wrStall} = 3'b000;
        coreIn = '0;
        doReset(1'b1, 3'h5, 5'h07);
        testFlow();
        testStall();
        testFill();
        testHand();
        doReset(1'b0, 3'h7, 5'h12);
        testFlow();
        finish_test();
    end
endmodule : processor_system_bus_port_bench
